// >>> src/pgm_cfg.svh
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef PGM_CFG_SVH
`define PGM_CFG_SVH

// register word addresses
`define PGM_A_G2_DATA   4'h0
`define PGM_A_G2_IOEN   4'h1
`define PGM_A_G2_PULL   4'h2
`define PGM_A_G2_IRQF   4'h3
`define PGM_A_G2_IRQC   4'h4
`define PGM_A_G2_FILT   4'h5
`define PGM_A_G2_MODE   4'h6
`define PGM_A_G2_FUNC   4'h7
`define PGM_A_G3_DATA   4'h8
`define PGM_A_G3_IOEN   4'h9
`define PGM_A_G3_PULL   4'hA
`define PGM_A_G3_IRQF   4'hB
`define PGM_A_G3_IRQC   4'hC
`define PGM_A_G3_FILT   4'hD
`define PGM_A_G3_MODE   4'hE
`define PGM_A_G3_FUNC   4'hF

// field positions
`define PGM_HI_LSB      8
`define PGM_LO_LSB      0
`define PGM_G3_P7_LSB   14

// function codes and reset values
`define PGM_FN0         2'h0
`define PGM_FN1         2'h1
`define PGM_FN2         2'h2
`define PGM_FN3         2'h3
`define PGM_RST2        2'h0
`define PGM_RST8        8'h00
`define PGM_RST16       16'h0000

// debounce timing: sample tick every DIV cycles, STABLE equal samples
`define PGM_FLT_DIV     8'd64
`define PGM_FLT_STABLE  3'd4

`endif

// >>> src/pgm_pkg.sv
package pgm_pkg;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pgm_pad_t;

  typedef struct packed {
    logic [1:0]  out_val;
    logic [1:0]  in_en;
    logic [1:0]  out_en;
    logic [1:0]  pull_dir;
    logic [1:0]  pull_en;
    logic [7:0]  sel2;
    logic [3:0]  fn2;
    logic [7:0]  sel3;
    logic [13:0] fn3;
    logic [1:0]  deb_en;
    logic [15:0] rdata;
    pgm_pad_t    pad2;
    pgm_pad_t    pad3;
    logic [1:0]  pad2_pull_en;
    logic [1:0]  pad2_pull_up;
    logic        ser_rx;
    logic        cmp_conn;
    logic [1:0]  tmr_clk;
    logic        spi_di;
    logic        spi_clk_in;
    logic        spi_ss_n;
  } pgm_state_t;

endpackage

// >>> src/pgm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pgm_sync #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst_sync_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pgm_sync_t;

  pgm_sync_t st_r;
  pgm_sync_t st_nxt;

  always_comb begin
    st_nxt.meta   = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;
endmodule
`default_nettype wire

// >>> src/pgm_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgm_cfg.svh"
module pgm_filter #(
  parameter logic [7:0] DIV    = `PGM_FLT_DIV,
  parameter logic [2:0] STABLE = `PGM_FLT_STABLE
) (
  input  wire logic       core_clk,
  input  wire logic       rst_sync_n,
  input  wire logic [1:0] raw_in,
  input  wire logic [1:0] enable,
  output logic      [1:0] clean_out
);
  typedef struct packed {
    logic [7:0] div;
    logic [2:0] cnt0;
    logic [2:0] cnt1;
    logic [1:0] level;
  } pgm_flt_t;

  pgm_flt_t st_r;
  pgm_flt_t st_nxt;
  logic     tick;

  always_comb begin
    st_nxt = st_r;
    tick   = (st_r.div == DIV - 8'd1);
    st_nxt.div = tick ? 8'h00 : st_r.div + 8'd1;
    // channel 0
    if (!enable[0]) begin
      st_nxt.level[0] = raw_in[0];
      st_nxt.cnt0     = 3'h0;
    end else if (tick) begin
      if (raw_in[0] == st_r.level[0]) begin
        st_nxt.cnt0 = 3'h0;
      end else if (st_r.cnt0 == STABLE - 3'd1) begin
        st_nxt.level[0] = raw_in[0];
        st_nxt.cnt0     = 3'h0;
      end else begin
        st_nxt.cnt0 = st_r.cnt0 + 3'd1;
      end
    end
    // channel 1
    if (!enable[1]) begin
      st_nxt.level[1] = raw_in[1];
      st_nxt.cnt1     = 3'h0;
    end else if (tick) begin
      if (raw_in[1] == st_r.level[1]) begin
        st_nxt.cnt1 = 3'h0;
      end else if (st_r.cnt1 == STABLE - 3'd1) begin
        st_nxt.level[1] = raw_in[1];
        st_nxt.cnt1     = 3'h0;
      end else begin
        st_nxt.cnt1 = st_r.cnt1 + 3'd1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clean_out = st_r.level;
endmodule
`default_nettype wire

// >>> src/pgm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgm_cfg.svh"
module pgm_top
  import pgm_pkg::*;
#(
  parameter logic [7:0] FLT_DIV    = `PGM_FLT_DIV,
  parameter logic [2:0] FLT_STABLE = `PGM_FLT_STABLE
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // pads
  input  wire logic [7:0]  group2_pin_in,
  output pgm_pad_t         group2_pad,
  output logic      [1:0]  group2_pad_pull_en,
  output logic      [1:0]  group2_pad_pull_up,
  input  wire logic [7:0]  group3_pin_in,
  output pgm_pad_t         group3_pad,
  // peripheral side
  output logic             serial_receive_in,
  input  wire logic        serial_transmit_out,
  input  wire logic        sensor_enable_out,
  output logic             comparator_positive_in,
  input  wire logic [21:7] segment_out,
  output logic      [1:0]  timer_external_clock,
  input  wire logic        clock_generator_out,
  output logic             spi1_data_in,
  input  wire logic        spi1_data_out,
  input  wire logic        spi1_clock_out,
  input  wire logic        spi1_clock_oe,
  output logic             spi1_clock_in,
  output logic             spi1_slave_select_n
);

  //------------------------------------------------------------
  // reset release
  //------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  //------------------------------------------------------------
  // pin input synchronisers and debounce
  //------------------------------------------------------------
  logic [7:0] g2_in;
  logic [7:0] g3_in;
  logic [1:0] g3_clean;

  pgm_sync #(.W(8)) u_sync2 (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .async_in   (group2_pin_in),
    .sync_out   (g2_in)
  );

  pgm_sync #(.W(8)) u_sync3 (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .async_in   (group3_pin_in),
    .sync_out   (g3_in)
  );

  pgm_state_t st_r;
  pgm_state_t st_nxt;

  // debounce is in series with the timer clock path only
  pgm_filter #(.DIV(FLT_DIV), .STABLE(FLT_STABLE)) u_filter (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .raw_in     (g3_in[1:0]),
    .enable     (st_r.deb_en),
    .clean_out  (g3_clean)
  );

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  // true when a pin is in peripheral mode with the given function
  function automatic logic routed(input logic sel, input logic [1:0] fn, input logic [1:0] want);
    routed = sel && (fn == want);
  endfunction

  // full 2-bit function of a second-group pin; pins 2-7 are hardwired
  function automatic logic [1:0] g2_fn(input logic [3:0] fn, input int p);
    if (p < 2) begin
      g2_fn = fn[p*2 +: 2];
    end else begin
      g2_fn = `PGM_FN3;
    end
  endfunction

  function automatic logic [1:0] g3_fn(input logic [13:0] fn, input int p);
    if (p < 7) begin
      g3_fn = fn[p*2 +: 2];
    end else begin
      g3_fn = `PGM_FN3;
    end
  endfunction

  //------------------------------------------------------------
  // register readback views
  //------------------------------------------------------------
  logic [15:0] g2_func_view;
  logic [15:0] g3_func_view;
  logic [1:0]  in_level;

  always_comb begin
    g2_func_view = {12'hFFF, st_r.fn2};
    g3_func_view = {`PGM_FN3, st_r.fn3};
    in_level     = g2_in[1:0] & st_r.in_en;
  end

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // register writes; read-only fields are simply not stored
    if (reg_wr) begin
      case (reg_addr)
        `PGM_A_G2_DATA: begin
          st_nxt.out_val = reg_wdata[`PGM_HI_LSB +: 2];
        end
        `PGM_A_G2_IOEN: begin
          st_nxt.in_en  = reg_wdata[`PGM_HI_LSB +: 2];
          st_nxt.out_en = reg_wdata[`PGM_LO_LSB +: 2];
        end
        `PGM_A_G2_PULL: begin
          st_nxt.pull_dir = reg_wdata[`PGM_HI_LSB +: 2];
          st_nxt.pull_en  = reg_wdata[`PGM_LO_LSB +: 2];
        end
        `PGM_A_G2_MODE: begin
          st_nxt.sel2 = reg_wdata[`PGM_LO_LSB +: 8];
        end
        `PGM_A_G2_FUNC: begin
          st_nxt.fn2 = reg_wdata[`PGM_LO_LSB +: 4];
        end
        `PGM_A_G3_FILT: begin
          st_nxt.deb_en = reg_wdata[`PGM_LO_LSB +: 2];
        end
        `PGM_A_G3_MODE: begin
          st_nxt.sel3 = reg_wdata[`PGM_LO_LSB +: 8];
        end
        `PGM_A_G3_FUNC: begin
          st_nxt.fn3 = reg_wdata[`PGM_LO_LSB +: 14];
        end
        default: begin
          // irq, second-group filter and all third-group gpio registers ignore writes
          st_nxt.rdata = st_r.rdata;
        end
      endcase
    end

    // reads answer one cycle later; unmapped and empty registers give zero
    if (reg_rd) begin
      case (reg_addr)
        `PGM_A_G2_DATA: begin
          st_nxt.rdata = {6'h00, st_r.out_val, 6'h00, in_level};
        end
        `PGM_A_G2_IOEN: begin
          st_nxt.rdata = {6'h00, st_r.in_en, 6'h00, st_r.out_en};
        end
        `PGM_A_G2_PULL: begin
          st_nxt.rdata = {6'h00, st_r.pull_dir, 6'h00, st_r.pull_en};
        end
        `PGM_A_G2_MODE: begin
          st_nxt.rdata = {8'h00, st_r.sel2};
        end
        `PGM_A_G2_FUNC: begin
          st_nxt.rdata = g2_func_view;
        end
        `PGM_A_G3_FILT: begin
          st_nxt.rdata = {14'h0000, st_r.deb_en};
        end
        `PGM_A_G3_MODE: begin
          st_nxt.rdata = {8'h00, st_r.sel3};
        end
        `PGM_A_G3_FUNC: begin
          st_nxt.rdata = g3_func_view;
        end
        default: begin
          st_nxt.rdata = `PGM_RST16;
        end
      endcase
    end

    // second group pads: an unassigned function leaves the pad floating
    st_nxt.pad2 = '0;
    for (int p = 0; p < 8; p++) begin
      if (!st_r.sel2[p]) begin
        if (p < 2) begin
          st_nxt.pad2.o[p]  = st_r.out_val[p];
          st_nxt.pad2.oe[p] = st_r.out_en[p];
        end
      end else if (g2_fn(st_r.fn2, p) == `PGM_FN3 && p >= 1) begin
        // pin 1 carries segment 7, so pin p carries segment p + 6
        st_nxt.pad2.o[p]  = segment_out[p + 6];
        st_nxt.pad2.oe[p] = 1'b1;
      end
    end
    if (routed(st_r.sel2[1], st_r.fn2[3:2], `PGM_FN0)) begin
      st_nxt.pad2.o[1]  = serial_transmit_out;
      st_nxt.pad2.oe[1] = 1'b1;
    end
    if (routed(st_r.sel2[1], st_r.fn2[3:2], `PGM_FN1)) begin
      st_nxt.pad2.o[1]  = sensor_enable_out;
      st_nxt.pad2.oe[1] = 1'b1;
    end

    // pulls only act while the pin is in GPIO mode
    for (int p = 0; p < 2; p++) begin
      st_nxt.pad2_pull_en[p] = st_r.pull_en[p] & ~st_r.sel2[p];
      st_nxt.pad2_pull_up[p] = st_r.pull_dir[p];
    end

    // third group pads: no gpio, so mode 0 leaves the pad floating
    st_nxt.pad3 = '0;
    for (int p = 0; p < 8; p++) begin
      if (routed(st_r.sel3[p], g3_fn(st_r.fn3, p), `PGM_FN3)) begin
        st_nxt.pad3.o[p]  = segment_out[p + 14];
        st_nxt.pad3.oe[p] = 1'b1;
      end
    end
    if (routed(st_r.sel3[2], st_r.fn3[5:4], `PGM_FN0)) begin
      st_nxt.pad3.o[2]  = clock_generator_out;
      st_nxt.pad3.oe[2] = 1'b1;
    end
    if (routed(st_r.sel3[4], st_r.fn3[9:8], `PGM_FN0)) begin
      st_nxt.pad3.o[4]  = spi1_data_out;
      st_nxt.pad3.oe[4] = 1'b1;
    end
    if (routed(st_r.sel3[5], st_r.fn3[11:10], `PGM_FN0)) begin
      st_nxt.pad3.o[5]  = spi1_clock_out;
      st_nxt.pad3.oe[5] = spi1_clock_oe;
    end

    // peripheral inputs; disconnected inputs sit at their idle level
    st_nxt.ser_rx = routed(st_r.sel2[0], st_r.fn2[1:0], `PGM_FN0) ? g2_in[0] : 1'b1;
    st_nxt.cmp_conn = routed(st_r.sel2[0], st_r.fn2[1:0], `PGM_FN2);
    for (int c = 0; c < 2; c++) begin
      st_nxt.tmr_clk[c] = routed(st_r.sel3[c], st_r.fn3[c*2 +: 2], `PGM_FN0)
                          ? g3_clean[c] : 1'b0;
    end
    st_nxt.spi_di     = routed(st_r.sel3[3], st_r.fn3[7:6], `PGM_FN0) ? g3_in[3] : 1'b0;
    st_nxt.spi_clk_in = routed(st_r.sel3[5], st_r.fn3[11:10], `PGM_FN0) ? g3_in[5] : 1'b0;
    st_nxt.spi_ss_n   = routed(st_r.sel3[6], st_r.fn3[13:12], `PGM_FN0) ? g3_in[6] : 1'b1;
  end

  //------------------------------------------------------------
  // state register
  //------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r          <= '0;
      st_r.ser_rx   <= 1'b1;
      st_r.spi_ss_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  //------------------------------------------------------------
  // outputs, all straight from st_r
  //------------------------------------------------------------
  assign reg_rdata              = st_r.rdata;
  assign group2_pad             = st_r.pad2;
  assign group2_pad_pull_en     = st_r.pad2_pull_en;
  assign group2_pad_pull_up     = st_r.pad2_pull_up;
  assign group3_pad             = st_r.pad3;
  assign serial_receive_in      = st_r.ser_rx;
  assign comparator_positive_in = st_r.cmp_conn;
  assign timer_external_clock   = st_r.tmr_clk;
  assign spi1_data_in           = st_r.spi_di;
  assign spi1_clock_in          = st_r.spi_clk_in;
  assign spi1_slave_select_n    = st_r.spi_ss_n;

endmodule
`default_nettype wire

// >>> tb/pgm_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pgm_top_chk
  import pgm_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire pgm_pad_t    group2_pad,
  input wire pgm_pad_t    group3_pad,
  input wire logic        serial_receive_in,
  input wire logic [21:7] segment_out,
  input wire logic [1:0]  timer_external_clock
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // shadow of both mode fields, followed from bus writes
  logic [7:0] md2_r;
  logic [7:0] md3_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      md2_r <= 8'h00;
      md3_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 4'h6) md2_r <= reg_wdata[7:0];
      if (reg_addr == 4'hE) md3_r <= reg_wdata[7:0];
    end
  end

  AST_RSVD_ZERO: assert property (
    reg_rd && reg_addr inside {4'h3, 4'h4, 4'h5, [4'h8:4'hC]} |=> reg_rdata == 16'h0000)
    else $error("reserved register read nonzero");
  AST_GPIO_BITS: assert property (
    reg_rd && reg_addr <= 4'h2 |=> (reg_rdata & 16'hFCFC) == 16'h0000)
    else $error("unused gpio bit set");
  AST_MODE_HI: assert property (
    reg_rd && (reg_addr == 4'h6 || reg_addr == 4'hE) |=> reg_rdata[15:8] == 8'h00)
    else $error("mode upper byte set");
  AST_FUNC2_FIXED: assert property (
    reg_rd && reg_addr == 4'h7 |=> reg_rdata[15:4] == 12'hFFF)
    else $error("fixed functions of group 2 wrong");
  AST_FUNC3_FIXED: assert property (
    reg_rd && reg_addr == 4'hF |=> reg_rdata[15:14] == 2'h3)
    else $error("fixed function of group 3 pin 7 wrong");
  AST_FILT3_BITS: assert property (
    reg_rd && reg_addr == 4'hD |=> reg_rdata[15:2] == 14'h0000)
    else $error("filter enable upper bits set");
  AST_G2_NO_GPIO: assert property (
    md2_r[7:2] == 6'h00 && $past(md2_r[7:2]) == 6'h00 |-> group2_pad.oe[7:2] == 6'h00)
    else $error("group 2 upper pins driven in gpio mode");
  AST_G3_NO_GPIO: assert property (
    md3_r == 8'h00 && $past(md3_r) == 8'h00 |-> group3_pad.oe == 8'h00)
    else $error("group 3 pin driven in gpio mode");
  AST_G2_SEG: assert property (
    md2_r[2] && $past(md2_r[2]) |-> group2_pad.oe[2] && group2_pad.o[2] == $past(segment_out[8]))
    else $error("group 2 pin 2 not following segment");
  AST_RX_IDLE: assert property (
    !md2_r[0] && !$past(md2_r[0]) |-> serial_receive_in)
    else $error("serial receive not idle in gpio mode");
  AST_TMR_IDLE: assert property (
    (md3_r[1:0] == 2'b00) [*3] |-> timer_external_clock == 2'b00)
    else $error("timer clock active in gpio mode");

  cover property (reg_rd && reg_addr == 4'h7);
  cover property (md2_r[1] && group2_pad.oe[1]);
  cover property ($rose(timer_external_clock[0]));
endmodule

bind pgm_top pgm_top_chk u_chk (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .group2_pad, .group3_pad, .serial_receive_in, .segment_out, .timer_external_clock);
`default_nettype wire

// >>> tb/pgm_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module pgm_pad_model
  import pgm_pkg::*;
(
  input  wire logic       core_clk,
  input  wire pgm_pad_t   pad,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] pull_en,
  input  wire logic [7:0] pull_up,
  output logic      [7:0] lvl
);
  // an undriven pad with no pull enabled toggles so a stale level can never pass a check
  logic [7:0] flt_r = 8'h00;
  always_ff @(posedge core_clk)
    flt_r <= ~flt_r;
  assign lvl = (pad.oe & pad.o) | (~pad.oe & ext_en & ext_val)
             | (~pad.oe & ~ext_en & ((pull_en & pull_up) | (~pull_en & flt_r)));
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
  import pgm_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [7:0]  group2_pin_in, group3_pin_in;
  pgm_pad_t    group2_pad, group3_pad;
  logic [1:0]  group2_pad_pull_en, group2_pad_pull_up, timer_external_clock;
  logic        serial_receive_in, comparator_positive_in, spi1_data_in, spi1_clock_in, spi1_slave_select_n;
  logic        serial_transmit_out = 1'b1;
  logic        sensor_enable_out = 1'b0;
  logic [21:7] segment_out = 15'h2B4D;
  logic        clock_generator_out = 1'b1;
  logic        spi1_data_out = 1'b0;
  logic        spi1_clock_out = 1'b1;
  logic        spi1_clock_oe = 1'b1;
  logic [7:0]  x2_v = 8'h00, x2_e = 8'h00, x3_v = 8'h00, x3_e = 8'h00, o8;
  logic        p1;
  int          errors = 0, tests_run = 0;
  localparam logic [15:0] E0 [16] = '{0, 0, 0, 0, 0, 0, 0, 16'hFFF0, 0, 0, 0, 0, 0, 0, 0, 16'hC000};
  localparam logic [15:0] E1 [16] = '{16'h0300, 16'h0303, 16'h0303, 0, 0, 0, 16'h00FF, 16'hFFFF,
                                      0, 0, 0, 0, 0, 16'h0003, 16'h00FF, 16'hFFFF};

  always #5 core_clk = ~core_clk;

  // short filter timing keeps the debounce runs brief
  pgm_top #(.FLT_DIV(8'h02), .FLT_STABLE(3'h2)) DUT (.*);
  pgm_pad_model u_p2 (.core_clk, .pad(group2_pad), .ext_val(x2_v), .ext_en(x2_e),
    .pull_en({6'h00, group2_pad_pull_en}), .pull_up({6'h00, group2_pad_pull_up}), .lvl(group2_pin_in));
  pgm_pad_model u_p3 (.core_clk, .pad(group3_pad), .ext_val(x3_v), .ext_en(x3_e),
    .pull_en(8'h00), .pull_up(8'h00), .lvl(group3_pin_in));

  // --------
  // bus, wait and finish tasks
  // --------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk_all(input logic [15:0] e [16]);
    logic [15:0] v;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), v);
      `CHK("register", e[a], v & (a == 0 ? 16'hFFFC : 16'hFFFF))
    end
  endtask
  task automatic wait_tmr(input logic [1:0] e);
    int n;
    n = 0;
    while (timer_external_clock !== e && n < 100) begin
      @(posedge core_clk);
      #1 n++;
    end
    `CHK("timer clock", e, timer_external_clock)
    if (n == 100)
      test_done;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    test_done;
  end

  // --------
  // main sequence
  // --------
  initial begin
    logic [15:0] v;
    int n;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(3);
    chk_all(E0);
    for (int a = 0; a < 16; a++)
      wr(4'(a), 16'hFFFF);
    chk_all(E1);
    for (int a = 0; a < 16; a++)
      wr(4'(a), 16'h0000);
    chk_all(E0);
    x2_e <= 8'h02;
    x2_v <= 8'h02;
    wr(4'h1, 16'h0301);
    wr(4'h0, 16'h0100);
    cyc(4);
    `CHK("g2 oe", 8'h01, group2_pad.oe)
    `CHK("g2 out", 1'b1, group2_pad.o[0])
    rd(4'h0, v);
    `CHK("g2 data", 16'h0103, v)
    wr(4'h2, 16'h0202);
    x2_e <= 8'h00;
    cyc(4);
    `CHK("g2 pull", 4'hA, {group2_pad_pull_en, group2_pad_pull_up})
    rd(4'h0, v);
    `CHK("g2 pulled up", 16'h0103, v)
    wr(4'h2, 16'h0002);
    cyc(4);
    rd(4'h0, v);
    `CHK("g2 pulled down", 16'h0101, v)
    wr(4'h1, 16'h0001);
    rd(4'h0, v);
    `CHK("g2 input off", 16'h0100, v)
    x2_e <= 8'h01;
    x2_v <= 8'h00;
    serial_transmit_out <= 1'b0;
    sensor_enable_out <= 1'b1;
    wr(4'h6, 16'h00FF);
    for (int f = 0; f < 4; f++) begin
      wr(4'h7, {12'h000, 2'(f), 2'(f)});
      cyc(4);
      p1 = f == 1 ? sensor_enable_out : f == 3 ? segment_out[7] : serial_transmit_out;
      `CHK("rx", f != 0, serial_receive_in)
      `CHK("cmp", f == 2, comparator_positive_in)
      `CHK("g2 oe", {6'h3F, f != 2, 1'b0}, group2_pad.oe)
      `CHK("g2 pin1", p1 | (f == 2), group2_pad.o[1] | (f == 2))
      `CHK("g2 seg", segment_out[13:8], group2_pad.o[7:2])
    end
    x3_e <= 8'h4B;
    x3_v <= 8'h0B;
    segment_out <= 15'h5AB2;
    spi1_data_out <= 1'b1;
    wr(4'hE, 16'h00FF);
    wr(4'hF, 16'h0000);
    wait_tmr(2'b11);
    o8 = {segment_out[21], 1'b0, spi1_clock_out, spi1_data_out, 1'b0, clock_generator_out, 2'b00};
    `CHK("g3 oe", 8'hB4, group3_pad.oe)
    `CHK("g3 out", o8, group3_pad.o & 8'hB4)
    `CHK("spi in", 2'b10, {spi1_data_in, spi1_slave_select_n})
    `CHK("spi clk in", spi1_clock_out, spi1_clock_in)
    wr(4'hD, 16'h0003);
    x3_v <= 8'h0A;
    @(posedge core_clk);
    x3_v <= 8'h0B;
    n = 0;
    repeat (20) begin
      @(posedge core_clk);
      #1;
      if (timer_external_clock[0] !== 1'b1)
        n++;
    end
    `CHK("glitch", 0, n)
    @(posedge core_clk);
    x3_v <= 8'h08;
    wait_tmr(2'b00);
    wr(4'hF, 16'hFFFF);
    cyc(4);
    `CHK("g3 seg", {8'hFF, segment_out[21:14]}, {group3_pad.oe, group3_pad.o})
    `CHK("g3 idle", 3'b001, {timer_external_clock, spi1_slave_select_n})
    wr(4'hF, 16'h5555);
    cyc(4);
    `CHK("g3 unassigned", 8'h80, group3_pad.oe)
    `CHK("spi idle", 2'b01, {spi1_data_in, spi1_slave_select_n})
    test_done;
  end
endmodule
`default_nettype wire
